// ### core/bpe_pkg.sv
// Event codes, widths and reset values for the basic event counter
// How it works
// - Code 0x002 adds one per back-end execution cycle, never more.
// - Code 0x003 adds one per cycle spent in low-power halted state.
// - Halted count covers both threads; foreground is set minus clear count.
// - Code 0x004 starts counting when a valid channel 0 tag appears.
// - Tagged counting stops on a channel 1 tag without channel 0 tag.
// - Code 0x001 counts timebase reference cycles spent in the back-end.
// - Code 0x875 counts cycles the front end works on the thread.
// - Code 0x005 adds up to 12 retired instructions per cycle.
package bpe_pkg;
  localparam int          CODE_W       = 12;
  localparam int          CNT_W        = 48;
  localparam int          INC_W        = 4;
  localparam int          RET_W        = 4;
  localparam logic [11:0] EV_REF_CYC   = 12'h001;
  localparam logic [11:0] EV_OP_CYC    = 12'h002;
  localparam logic [11:0] EV_HALTED    = 12'h003;
  localparam logic [11:0] EV_TAGGED    = 12'h004;
  localparam logic [11:0] EV_RETIRED   = 12'h005;
  localparam logic [11:0] EV_FE_CYC    = 12'h875;
  localparam logic [3:0]  MAX_RETIRE   = 4'hc;
  localparam logic [47:0] CNT_RESET    = 48'h0;

  // Per-cycle activity reported by the core
  typedef struct packed {
    logic       backend_cycle;
    logic       halted_fg;
    logic       halted_bg;
    logic       tag_ch0;
    logic       tag_ch1;
    logic       timebase_tick;
    logic       fe_thread_cycle;
    logic [3:0] retired;
  } bpe_activity_t;

  // Software selection
  typedef struct packed {
    logic [11:0] code;
    logic        thread_channel_bit;
  } bpe_select_t;
endpackage : bpe_pkg

// ### core/bpe_counter.sv
// Basic performance event increment and accumulation logic
`timescale 1ns/100ps
module bpe_counter (
  // Clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  // Core activity and selection
  input  wire bpe_pkg::bpe_activity_t act_i,
  input  wire bpe_pkg::bpe_select_t   sel_i,
  // Results
  output logic [3:0]                  inc_o,
  output logic                        tag_active_o,
  output logic [47:0]                 count_o
);

  typedef enum logic [1:0] {
    BPE_TAG_IDLE = 2'b01,
    BPE_TAG_RUN  = 2'b10
  } bpe_tag_state_t;

  bpe_tag_state_t tag_state;
  bpe_tag_state_t next_tag_state;
  logic [3:0]     next_inc;
  logic           tag_count;
  logic [3:0]     ret_clip;

  // Tag window: opens on channel 0, closes on channel 1 alone
  always_comb begin
    next_tag_state = tag_state;
    case (tag_state)
      BPE_TAG_IDLE: begin
        if (act_i.tag_ch0) begin
          next_tag_state = BPE_TAG_RUN;
        end
      end
      BPE_TAG_RUN: begin
        if (act_i.tag_ch1 && !act_i.tag_ch0) begin
          next_tag_state = BPE_TAG_IDLE;
        end
      end
      default: next_tag_state = BPE_TAG_IDLE;
    endcase
  end

  // Cycle opening the window already counts; the closing one does too
  assign tag_count = (tag_state == BPE_TAG_RUN) || act_i.tag_ch0;

  // Clip guards the accumulator against a faulty retire report
  assign ret_clip = (act_i.retired > bpe_pkg::MAX_RETIRE)
                    ? bpe_pkg::MAX_RETIRE : act_i.retired;

  // Event selection; each case yields the increment for this cycle
  always_comb begin
    next_inc = 4'h0;
    case (sel_i.code)
      bpe_pkg::EV_OP_CYC:
        next_inc = {3'h0, act_i.backend_cycle};
      bpe_pkg::EV_HALTED: begin
        // Bit set: either thread halted. Bit clear: only the background
        // halted, so set minus clear leaves exactly the foreground figure
        if (sel_i.thread_channel_bit) begin
          next_inc = {3'h0, act_i.halted_fg | act_i.halted_bg};
        end else begin
          next_inc = {3'h0, act_i.halted_bg & ~act_i.halted_fg};
        end
      end
      bpe_pkg::EV_TAGGED:
        next_inc = {3'h0, tag_count & act_i.backend_cycle};
      bpe_pkg::EV_REF_CYC:
        next_inc = {3'h0, act_i.timebase_tick & act_i.backend_cycle};
      bpe_pkg::EV_FE_CYC:
        next_inc = {3'h0, act_i.fe_thread_cycle};
      bpe_pkg::EV_RETIRED:
        next_inc = ret_clip;
      default: next_inc = 4'h0;
    endcase
  end

  // Tag state register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tag_state <= BPE_TAG_IDLE;
    end else begin
      tag_state <= next_tag_state;
    end
  end

  // Registered increment and tag flag
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inc_o        <= 4'h0;
      tag_active_o <= 1'b0;
    end else begin
      inc_o        <= next_inc;
      tag_active_o <= (next_tag_state == BPE_TAG_RUN);
    end
  end

  // Accumulator, one cycle behind the registered increment
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= bpe_pkg::CNT_RESET;
    end else begin
      count_o <= count_o + {44'h0, inc_o};
    end
  end

  // Checks
  property p_op_cyc;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sel_i.code == bpe_pkg::EV_OP_CYC |=> inc_o == $past(act_i.backend_cycle);
  endproperty
  a_op_cyc: assert property (p_op_cyc)
    else $error("op cycle inc wrong");

  property p_halted;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sel_i.code == bpe_pkg::EV_HALTED && sel_i.thread_channel_bit
      && (act_i.halted_fg || act_i.halted_bg) |=> inc_o == 4'h1;
  endproperty
  a_halted: assert property (p_halted)
    else $error("halted inc missing");

  property p_halted_bg;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sel_i.code == bpe_pkg::EV_HALTED && !sel_i.thread_channel_bit
      && act_i.halted_bg && !act_i.halted_fg |=> inc_o == 4'h1;
  endproperty
  a_halted_bg: assert property (p_halted_bg)
    else $error("bg halt missing");

  // With the bit clear a foreground halt must not count
  property p_halted_fg;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sel_i.code == bpe_pkg::EV_HALTED && !sel_i.thread_channel_bit
      && act_i.halted_fg |=> inc_o == 4'h0;
  endproperty
  a_halted_fg: assert property (p_halted_fg)
    else $error("fg halt counted with bit clear");

  property p_tag_start;
    @(posedge mclk_i) disable iff (!rst_n_i)
      act_i.tag_ch0 |=> tag_active_o;
  endproperty
  a_tag_start: assert property (p_tag_start)
    else $error("tag no start");

  property p_tag_stop;
    @(posedge mclk_i) disable iff (!rst_n_i)
      act_i.tag_ch1 && !act_i.tag_ch0 |=> !tag_active_o;
  endproperty
  a_tag_stop: assert property (p_tag_stop)
    else $error("tag no stop");

  // The opening cycle counts at once
  property p_tag_open;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sel_i.code == bpe_pkg::EV_TAGGED && act_i.tag_ch0
      && act_i.backend_cycle |=> inc_o == 4'h1;
  endproperty
  a_tag_open: assert property (p_tag_open)
    else $error("opening tag cycle not counted");

  // Sampled flag equals the window state of the same cycle
  property p_tag_run;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sel_i.code == bpe_pkg::EV_TAGGED && tag_active_o
      && act_i.backend_cycle |=> inc_o == 4'h1;
  endproperty
  a_tag_run: assert property (p_tag_run)
    else $error("open tag window not counted");

  property p_tag_idle;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sel_i.code == bpe_pkg::EV_TAGGED && !tag_active_o
      && !act_i.tag_ch0 |=> inc_o == 4'h0;
  endproperty
  a_tag_idle: assert property (p_tag_idle)
    else $error("closed tag window counted");

  property p_ref;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sel_i.code == bpe_pkg::EV_REF_CYC |=>
        inc_o == {3'h0, $past(act_i.timebase_tick & act_i.backend_cycle)};
  endproperty
  a_ref: assert property (p_ref)
    else $error("ref inc wrong");

  property p_fe;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sel_i.code == bpe_pkg::EV_FE_CYC |=>
        inc_o == {3'h0, $past(act_i.fe_thread_cycle)};
  endproperty
  a_fe: assert property (p_fe)
    else $error("fe inc wrong");

  property p_ret;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sel_i.code == bpe_pkg::EV_RETIRED
      && act_i.retired <= bpe_pkg::MAX_RETIRE |=>
        inc_o == $past(act_i.retired);
  endproperty
  a_ret: assert property (p_ret)
    else $error("retire inc wrong");

  // Every event but retirement is a cycle count, one at most
  property p_one_max;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sel_i.code != bpe_pkg::EV_RETIRED |=> inc_o <= 4'h1;
  endproperty
  a_one_max: assert property (p_one_max)
    else $error("more than one per cycle");

  // A faulty retire report is clipped, never passed through
  property p_ret_clip;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sel_i.code == bpe_pkg::EV_RETIRED
      && act_i.retired > bpe_pkg::MAX_RETIRE
      |=> inc_o == bpe_pkg::MAX_RETIRE;
  endproperty
  a_ret_clip: assert property (p_ret_clip)
    else $error("retire inc not clipped");

  property p_acc;
    @(posedge mclk_i) disable iff (!rst_n_i)
      ##1 count_o == $past(count_o) + {44'h0, $past(inc_o)};
  endproperty
  a_acc: assert property (p_acc)
    else $error("accumulate wrong");

  c_tag: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    act_i.tag_ch0 ##[1:20] (act_i.tag_ch1 && !act_i.tag_ch0));
  c_ret12: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    inc_o == 4'hc);
  c_halt: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    sel_i.code == bpe_pkg::EV_HALTED ##1 inc_o == 4'h1);
  c_halt_bg: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    sel_i.code == bpe_pkg::EV_HALTED && !sel_i.thread_channel_bit
    && act_i.halted_bg ##1 inc_o == 4'h1);

endmodule : bpe_counter

// ### testbench/basic_perf_event_counting_test.sv
// Self-checking bench for the basic event counter
`timescale 1ns/100ps
module basic_perf_event_counting_test;
  logic                   mclk_i = 1'b0;
  logic                   rst_n_i = 1'b0;
  bpe_pkg::bpe_activity_t act_i = 11'h000;
  bpe_pkg::bpe_select_t   sel_i = 13'h0000;
  logic [3:0]             inc_o;
  logic                   tag_active_o;
  logic [47:0]            count_o;
  logic [3:0]             pend = 4'h0;
  logic                   pend_tag = 1'b0;
  logic [47:0]            esum = 48'h0;
  int                     n_mismatch = 0;
  int                     checks = 0;
  int                     cycles = 0;

  bpe_counter i_dut (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n_i),
    .act_i        (act_i),
    .sel_i        (sel_i),
    .inc_o        (inc_o),
    .tag_active_o (tag_active_o),
    .count_o      (count_o)
  );

  // 250 MHz core clock
  always #2 mclk_i = ~mclk_i;

  // Hang guard, far above the few dozen cycles the tests need
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task cmp(string what, logic [47:0] exp, logic [47:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Outputs lag one edge, so each step judges the previous step
  task st(logic [11:0] c, logic ch, logic [10:0] a, logic [3:0] e,
          logic t);
    @(posedge mclk_i);
    sel_i <= {c, ch};
    act_i <= a;
    #1;
    cmp("count_o", esum, count_o);
    cmp("inc_o", {44'h0, pend}, {44'h0, inc_o});
    cmp("tag_active_o", {47'h0, pend_tag}, {47'h0, tag_active_o});
    esum = esum + {44'h0, pend};
    pend = e;
    pend_tag = t;
  endtask : st

  task t_op();
    st(12'h002, 1'b0, 11'h400, 4'h1, 1'b0);
    st(12'h002, 1'b0, 11'h73c, 4'h1, 1'b0);
    st(12'h002, 1'b0, 11'h000, 4'h0, 1'b0);
    st(12'h7ff, 1'b0, 11'h73c, 4'h0, 1'b0);
  endtask : t_op

  // Set bit counts either thread; clear bit counts background-only halts
  task t_halt();
    st(12'h003, 1'b1, 11'h100, 4'h1, 1'b0);
    st(12'h003, 1'b0, 11'h100, 4'h1, 1'b0);
    st(12'h003, 1'b0, 11'h200, 4'h0, 1'b0);
    st(12'h003, 1'b0, 11'h300, 4'h0, 1'b0);
    st(12'h003, 1'b1, 11'h300, 4'h1, 1'b0);
    st(12'h003, 1'b1, 11'h200, 4'h1, 1'b0);
    st(12'h003, 1'b1, 11'h000, 4'h0, 1'b0);
  endtask : t_halt

  task t_misc();
    st(12'h001, 1'b0, 11'h420, 4'h1, 1'b0);
    st(12'h001, 1'b0, 11'h020, 4'h0, 1'b0);
    st(12'h001, 1'b0, 11'h400, 4'h0, 1'b0);
    st(12'h875, 1'b0, 11'h010, 4'h1, 1'b0);
    st(12'h875, 1'b0, 11'h400, 4'h0, 1'b0);
    st(12'h005, 1'b0, 11'h00c, 4'hc, 1'b0);
    st(12'h005, 1'b0, 11'h007, 4'h7, 1'b0);
    st(12'h005, 1'b0, 11'h00f, 4'hc, 1'b0);
  endtask : t_misc

  // Window opens on channel 0, closes on channel 1 alone
  task t_tag();
    st(12'h004, 1'b0, 11'h400, 4'h0, 1'b0);
    st(12'h004, 1'b0, 11'h480, 4'h1, 1'b1);
    st(12'h004, 1'b0, 11'h400, 4'h1, 1'b1);
    st(12'h004, 1'b0, 11'h4c0, 4'h1, 1'b1);
    st(12'h004, 1'b0, 11'h440, 4'h1, 1'b0);
    st(12'h004, 1'b0, 11'h400, 4'h0, 1'b0);
    st(12'h000, 1'b0, 11'h000, 4'h0, 1'b0);
  endtask : t_tag

  // Mid-run reset clears at once; counting restarts from zero after it
  task t_rst();
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    #1;
    cmp("count_o", 48'h0, count_o);
    cmp("inc_o", 48'h0, {44'h0, inc_o});
    @(posedge mclk_i);
    rst_n_i <= 1'b1;
    esum = 48'h0;
    pend = 4'h0;
    pend_tag = 1'b0;
    st(12'h002, 1'b0, 11'h400, 4'h1, 1'b0);
    st(12'h002, 1'b0, 11'h400, 4'h1, 1'b0);
    st(12'h000, 1'b0, 11'h000, 4'h0, 1'b0);
    st(12'h000, 1'b0, 11'h000, 4'h0, 1'b0);
  endtask : t_rst

  task end_sim();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  initial begin
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_op();
    t_halt();
    t_misc();
    t_tag();
    t_rst();
    end_sim();
  end
endmodule : basic_perf_event_counting_test
